/* include/mpc_pkg.sv */
// Constants and carrier types for the motor PWM current regulator.
// Assumes a single 50 MHz core clock; sampling times are scaled from a 4 MHz peripheral rate.
package mpc_pkg;
    // Core clock rate in kHz
    localparam int CLK_KHZ = 50000;
    // Peripheral reference rate that the printed times assume, in kHz
    localparam int PERIPH_KHZ = 4000;
    // Comparator sampling divider (one sample per four peripheral ticks)
    localparam int SAMPLE_DIV_PERIPH = 4;
    // Core cycles per sampling tick
    localparam int SAMPLE_DIV = SAMPLE_DIV_PERIPH * CLK_KHZ / PERIPH_KHZ;
    localparam logic [7:0] SAMPLE_LAST = 8'(SAMPLE_DIV - 1);
    // Blanking step in ns, and the same step in core cycles
    localparam int BLANK_STEP_NS = 500;
    localparam int BLANK_STEP_CYC = (BLANK_STEP_NS * CLK_KHZ + 999999) / 1000000;
    localparam logic [7:0] BLANK_STEP = 8'(BLANK_STEP_CYC);
    // Blanking code that turns blanking off, and its reset value
    localparam logic [2:0] BLANK_OFF = 3'h0;
    // Filter code reset value (one sample needed)
    localparam logic [2:0] FILT_RST = 3'h0;
    // Window period table, 4-bit select, in ns at the reference rate
    localparam int WIN_NS [16] = '{20000, 25000, 30000, 40000, 50000, 55250, 64935, 80000,
                                   100000, 160000, 319489, 641025, 800000, 1040582, 1600000, 2564102};
    // Window low time, a fixed time whatever the period; counts are derived from it
    localparam int WIN_LOW_NS = 2500;
    localparam logic [23:0] WIN_LOW = 24'(WIN_LOW_NS * CLK_KHZ / 1000000);
    // Reset-state choices for the motor outputs
    typedef enum logic [1:0] {
        MPC_RST_HIZ = 2'h0,
        MPC_RST_HIGH = 2'h1,
        MPC_RST_LOW = 2'h2
    } mpc_rststate_e;
    // Control bits from software
    typedef struct packed {
        logic current_mode_select;
        logic limit_irq_mask;
        logic overcurrent_output_kill;
        logic clock_enable;
        logic dac_enable;
        logic [2:0] ref_out_enable;
        logic [2:0] blanking_window_len;
        logic [2:0] feedback_sample_count;
        logic [3:0] window_rate_select;
    } mpc_ctrl_s;
endpackage

/* rtl/mpc_filter.sv */
// Comparator sampling, blanking window and consecutive-sample filter.
// Assumes the comparator input is synchronous to the core clock.
`timescale 1ns/1ns
module mpc_filter import mpc_pkg::*; (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // Control
    input wire logic comp_on_i,
    input wire logic pwm_on_pulse_i,
    input wire logic [2:0] blank_len_i,
    input wire logic [2:0] filt_code_i,
    // Comparator and result
    input wire logic above_i,
    output logic limit_o
);
    // Sample tick divider, blanking counter, run counter
    logic [7:0] div_q, div_d;
    logic [10:0] blank_q, blank_d;
    logic [3:0] run_q, run_d;
    logic limit_q, limit_d;
    logic tick;

    // Next-state computation
    always_comb begin
        tick = (div_q == SAMPLE_LAST);
        div_d = tick ? 8'h00 : div_q + 8'h01;
        blank_d = blank_q;
        run_d = run_q;
        limit_d = limit_q;
        if (!comp_on_i) begin
            // Comparator off: no events
            run_d = 4'h0;
            limit_d = 1'b0;
            blank_d = 11'h000;
        end else if (pwm_on_pulse_i) begin
            // Blank from each turn-on, restart count
            blank_d = 11'(blank_len_i * BLANK_STEP);
            run_d = 4'h0;
            limit_d = 1'b0;
        end else begin
            if (blank_q != 11'h000) begin
                blank_d = blank_q - 11'h001;
            end
            if (tick && blank_q == 11'h000) begin
                if (!above_i) begin
                    run_d = 4'h0;
                    limit_d = 1'b0;
                end else if (run_q < {1'b0, filt_code_i}) begin
                    run_d = run_q + 4'h1;
                end else begin
                    limit_d = 1'b1;
                end
            end
        end
    end

    // Registers
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_q <= 8'h00;
            blank_q <= 11'h000;
            run_q <= 4'h0;
            limit_q <= 1'b0;
        end else begin
            div_q <= div_d;
            blank_q <= blank_d;
            run_q <= run_d;
            limit_q <= limit_d;
        end
    end

    assign limit_o = limit_q;

    // Limit never rises while comparator is off
    property p_off_quiet;
        @(posedge core_clk_i) disable iff (!rst_n_i) !comp_on_i |=> !limit_q;
    endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("limit while comparator off");

    // Limit only rises after filter count reached with input above
    property p_needs_count;
        @(posedge core_clk_i) disable iff (!rst_n_i) $rose(limit_q) |-> $past(run_q) == {1'b0, $past(filt_code_i)};
    endproperty
    a_needs_count: assert property (p_needs_count) else $error("limit before sample count");

    // Turn-on restarts the run counter
    property p_restart;
        @(posedge core_clk_i) disable iff (!rst_n_i) pwm_on_pulse_i |=> run_q == 4'h0 && !limit_q;
    endproperty
    a_restart: assert property (p_restart) else $error("counter not restarted");

    // Blanking loads its length at turn-on
    property p_blank;
        @(posedge core_clk_i) disable iff (!rst_n_i)
            comp_on_i && pwm_on_pulse_i |=> blank_q == 11'($past(blank_len_i) * BLANK_STEP);
    endproperty
    a_blank: assert property (p_blank) else $error("blank length wrong");

    // Sampling tick period
    property p_tick;
        @(posedge core_clk_i) disable iff (!rst_n_i) div_q == 8'h00 |=> div_q == 8'h01;
    endproperty
    a_tick: assert property (p_tick) else $error("sample divider stuck");
endmodule

/* rtl/mpc_pwm_mgr.sv */
// PWM manager: voltage/current mode selection, limiter and output kill.
// Assumes the PWM generator compares and the comparator level are synchronous inputs.
`timescale 1ns/1ns
module mpc_pwm_mgr import mpc_pkg::*; (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // Software control bits
    input wire mpc_ctrl_s ctrl_i,
    input wire logic master_enable_set_i,
    input wire logic limit_flag_clear_i,
    input wire mpc_rststate_e reset_state_opt_i,
    // PWM generator compares U, V, W
    input wire logic [2:0] phase_cmp_i,
    // Current comparator (sense above reference)
    input wire logic current_above_i,
    // Channel manager side
    input wire logic [5:0] phase_select_i,
    output logic pwm_o,
    output logic [5:0] motor_phase_outputs_o,
    output logic [5:0] motor_phase_oe_o,
    // Current reference outputs
    output logic phase_u_ref_out_o,
    output logic phase_v_ref_out_o,
    output logic phase_w_ref_out_o,
    // Status
    output logic output_master_enable_o,
    output logic limit_irq_flag_o,
    output logic limit_irq_o
);
    // Measurement window counter and level
    logic [23:0] win_q, win_d;
    logic win_q_lvl, win_d_lvl;
    logic [23:0] win_len;
    // PWM state and edge
    logic pwm_q, pwm_d;
    // Compare U of the previous cycle, for the generator's turn-on edge
    logic cmp_u_q, cmp_u_d;
    logic on_pulse;
    logic limit;
    logic comp_on;
    // Status registers
    logic moe_q, moe_d;
    logic flag_q, flag_d;
    logic irq_q, irq_d;
    logic [5:0] out_q, out_d, oe_q, oe_d;
    logic [2:0] ref_q, ref_d;
    // Blank and filter fields from software; reset value handled by caller reset
    logic [2:0] blank_len;

    // Window period lookup
    always_comb begin
        win_len = 24'(WIN_NS[ctrl_i.window_rate_select] * (CLK_KHZ / 1000) / 1000);
    end

    assign comp_on = ctrl_i.clock_enable | ctrl_i.dac_enable;
    assign blank_len = ctrl_i.blanking_window_len;

    // Filter instance
    mpc_filter u_filter (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .comp_on_i(comp_on),
        .pwm_on_pulse_i(on_pulse),
        .blank_len_i(blank_len),
        .filt_code_i(ctrl_i.feedback_sample_count),
        .above_i(current_above_i),
        .limit_o(limit)
    );

    // Window generator and PWM formation
    always_comb begin
        win_d = (win_q >= win_len - 24'h000001) ? 24'h000000 : win_q + 24'h000001;
        win_d_lvl = (win_d < WIN_LOW); // Window active during low part
        cmp_u_d = phase_cmp_i[0];
        on_pulse = 1'b0;
        if (ctrl_i.current_mode_select) begin
            // On at window end, off at next start or on limit
            pwm_d = pwm_q;
            if (win_q_lvl && !win_d_lvl) begin
                pwm_d = 1'b1;
                on_pulse = 1'b1;
            end else if (win_d_lvl || limit) begin
                pwm_d = 1'b0;
            end
        end else begin
            // Compare U, cut by the limiter
            pwm_d = phase_cmp_i[0] & ~limit;
            // Turn-on is the generator edge, so a cut PWM stays off until it recurs or a below-limit sample drops the limit
            on_pulse = phase_cmp_i[0] & ~cmp_u_q;
        end
    end

    // Flags, master enable and outputs
    always_comb begin
        flag_d = flag_q;
        moe_d = moe_q;
        if (limit_flag_clear_i) begin
            flag_d = 1'b0;
        end
        if (master_enable_set_i) begin
            moe_d = 1'b1;
        end
        // Set wins over clear; only voltage mode raises it
        if (limit && !ctrl_i.current_mode_select) begin
            flag_d = 1'b1;
            if (ctrl_i.limit_irq_mask && ctrl_i.overcurrent_output_kill) begin
                moe_d = 1'b0;
            end
        end
        irq_d = flag_d & ctrl_i.limit_irq_mask & ~ctrl_i.current_mode_select;
        // Reference outputs in current mode
        ref_d = ctrl_i.current_mode_select ? (phase_cmp_i & ctrl_i.ref_out_enable) : 3'h0;
        // Channel routing: PWM onto selected outputs, others low
        for (int i = 0; i < 6; i++) begin
            if (!moe_d) begin
                // Reset state from option
                out_d[i] = (reset_state_opt_i == MPC_RST_HIGH);
                oe_d[i] = (reset_state_opt_i != MPC_RST_HIZ);
            end else begin
                out_d[i] = pwm_d & phase_select_i[i];
                oe_d[i] = 1'b1;
            end
        end
    end

    // Registers
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            win_q <= 24'h000000;
            win_q_lvl <= 1'b1;
            pwm_q <= 1'b0;
            cmp_u_q <= 1'b0;
            moe_q <= 1'b0;
            flag_q <= 1'b0;
            irq_q <= 1'b0;
            ref_q <= 3'h0;
            out_q <= 6'h00;
            oe_q <= 6'h00;
        end else begin
            win_q <= win_d;
            win_q_lvl <= win_d_lvl;
            pwm_q <= pwm_d;
            cmp_u_q <= cmp_u_d;
            moe_q <= moe_d;
            flag_q <= flag_d;
            irq_q <= irq_d;
            ref_q <= ref_d;
            out_q <= out_d;
            oe_q <= oe_d;
        end
    end

    assign pwm_o = pwm_q;
    assign motor_phase_outputs_o = out_q;
    assign motor_phase_oe_o = oe_q;
    assign {phase_w_ref_out_o, phase_v_ref_out_o, phase_u_ref_out_o} = ref_q;
    assign output_master_enable_o = moe_q;
    assign limit_irq_flag_o = flag_q;
    assign limit_irq_o = irq_q;

    // Voltage mode follows compare U when no limit
    property p_vmode;
        @(posedge core_clk_i) disable iff (!rst_n_i)
            !ctrl_i.current_mode_select && !limit |=> pwm_q == $past(phase_cmp_i[0]);
    endproperty
    a_vmode: assert property (p_vmode) else $error("voltage mode pwm wrong");

    // Limit in voltage mode cuts pwm and sets flag
    property p_limit;
        @(posedge core_clk_i) disable iff (!rst_n_i) !ctrl_i.current_mode_select && limit |=> !pwm_q && flag_q;
    endproperty
    a_limit: assert property (p_limit) else $error("limit not applied");

    // No interrupt in current mode
    property p_cm_noirq;
        @(posedge core_clk_i) disable iff (!rst_n_i) ctrl_i.current_mode_select |=> !irq_q;
    endproperty
    a_cm_noirq: assert property (p_cm_noirq) else $error("irq in current mode");

    // Kill clear keeps master enable
    property p_nokill;
        @(posedge core_clk_i) disable iff (!rst_n_i) moe_q && !ctrl_i.overcurrent_output_kill |=> moe_q;
    endproperty
    a_nokill: assert property (p_nokill) else $error("enable dropped without kill");

    // Kill set with mask drops enable
    property p_kill;
        @(posedge core_clk_i) disable iff (!rst_n_i)
            limit && !ctrl_i.current_mode_select && ctrl_i.limit_irq_mask && ctrl_i.overcurrent_output_kill
            && !master_enable_set_i |=> !moe_q && oe_q == {6{$past(reset_state_opt_i) != MPC_RST_HIZ}}
            && out_q == {6{$past(reset_state_opt_i) == MPC_RST_HIGH}};
    endproperty
    a_kill: assert property (p_kill) else $error("kill not applied");

    // Current mode turns pwm on at window end
    sequence s_win_end;
        win_q_lvl && !win_d_lvl && ctrl_i.current_mode_select;
    endsequence
    property p_cmode_on;
        @(posedge core_clk_i) disable iff (!rst_n_i) s_win_end |=> pwm_q;
    endproperty
    a_cmode_on: assert property (p_cmode_on) else $error("pwm not on at window end");

    // Reference output gated by enable
    property p_ref;
        @(posedge core_clk_i) disable iff (!rst_n_i)
            ctrl_i.current_mode_select |=> ref_q == ($past(phase_cmp_i) & $past(ctrl_i.ref_out_enable));
    endproperty
    a_ref: assert property (p_ref) else $error("reference output wrong");

    // Output follows pwm on selected channel while enabled
    property p_route;
        @(posedge core_clk_i) disable iff (!rst_n_i) moe_q ##1 moe_q |-> out_q == ({6{pwm_q}} & $past(phase_select_i));
    endproperty
    a_route: assert property (p_route) else $error("routing wrong");
endmodule

/* dv/mpc_sense_model.sv */
// Behavioural current sense comparator that stands beside the PWM manager.
// Assumes the bench drives fault_i synchronously to the core clock.
`timescale 1ns/1ns
module mpc_sense_model (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // Fault request and response lag in core cycles
    input wire logic fault_i,
    input wire logic [7:0] lag_i,
    // Comparator result, high while sense is above reference
    output logic above_o
);
    // Cycles the fault has been present, saturating
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;

    // Next count: restart when the fault goes away
    always_comb begin
        cnt_d = cnt_q;
        if (!fault_i) begin
            cnt_d = 8'h00;
        end else if (cnt_q != 8'hFF) begin
            cnt_d = cnt_q + 8'h01;
        end
    end

    // Count register
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // Slow answer when lag is set, prompt when it is zero
    assign above_o = fault_i && (cnt_q >= lag_i);
endmodule

/* dv/motor_pwm_current_regulator_tb_top.sv */
// Self-checking bench for the PWM manager with its comparator model.
// Assumes one 50 MHz clock and the 50-cycle comparator sampling tick.
`timescale 1ns/1ns
module motor_pwm_current_regulator_tb_top import mpc_pkg::*;;
    // Stimulus
    logic core_clk, rst_n, me_set, fl_clr, fault;
    mpc_ctrl_s ctrl;
    mpc_rststate_e rso;
    logic [2:0] cmp;
    logic [5:0] sel;
    logic [7:0] lag;
    // Observed
    logic above, pwm, ref_u, ref_v, ref_w, men, flag, irq;
    logic [5:0] mpo, output_master_enable;
    int err_count, n_compared;

    mpc_pwm_mgr dut (.core_clk_i(core_clk), .rst_n_i(rst_n), .ctrl_i(ctrl), .master_enable_set_i(me_set),
        .limit_flag_clear_i(fl_clr), .reset_state_opt_i(rso), .phase_cmp_i(cmp), .current_above_i(above),
        .phase_select_i(sel), .pwm_o(pwm), .motor_phase_outputs_o(mpo), .motor_phase_oe_o(output_master_enable),
        .phase_u_ref_out_o(ref_u), .phase_v_ref_out_o(ref_v), .phase_w_ref_out_o(ref_w),
        .output_master_enable_o(men), .limit_irq_flag_o(flag), .limit_irq_o(irq));
    mpc_sense_model u_sense (.core_clk_i(core_clk), .rst_n_i(rst_n), .fault_i(fault), .lag_i(lag),
        .above_o(above));

    // Clock, 20 ns period
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // Verdict and end of run
    task automatic finish_test();
        $display("TB: compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Compare one observed value
    task automatic chk(input string what, input logic [5:0] exp, input logic [5:0] got);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    // Compare one cycle count
    task automatic chk_cnt(input string what, input logic [23:0] exp, input logic [23:0] got);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    // Let edges pass, then settle
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // Bounded wait for flag or pwm to reach a level
    task automatic wait_on(input bit use_flag, input logic val, input int max);
        int n;
        n = 0;
        while (((use_flag ? flag : pwm) !== val) && n < max) begin
            tick(1);
            n++;
        end
    endtask

    // Pulse master enable set for one cycle
    task automatic arm();
        @(posedge core_clk);
        me_set <= 1'b1;
        @(posedge core_clk);
        me_set <= 1'b0;
    endtask

    // Watchdog, well past the expected run length
    initial begin
        repeat (20000) @(posedge core_clk);
        err_count++;
        $display("MISMATCH watchdog expected done seen timeout");
        finish_test();
    end

    // Main sequence
    initial begin
        mpc_rststate_e opts [3];
        logic [5:0] exp_oe [3];
        logic [5:0] exp_out [3];
        int cyc;
        opts = '{MPC_RST_HIZ, MPC_RST_HIGH, MPC_RST_LOW};
        exp_oe = '{6'h00, 6'h3F, 6'h3F};
        exp_out = '{6'h00, 6'h3F, 6'h00};
        err_count = 0;
        n_compared = 0;
        ctrl = '0;
        me_set = 1'b0;
        fl_clr = 1'b0;
        rso = MPC_RST_HIZ;
        cmp = 3'h0;
        sel = 6'h3F;
        fault = 1'b0;
        lag = 8'h00;
        rst_n = 1'b0;
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        tick(2);
        // Idle state after reset
        chk("master_en", 1'b0, men);
        chk("flag", 1'b0, flag);
        chk("oe_reset", 6'h00, output_master_enable);
        $display("TB: test reset done");
        // Voltage mode follows the phase U compare only
        @(posedge core_clk);
        ctrl.limit_irq_mask <= 1'b1;
        arm();
        cmp <= 3'h1;
        tick(1);
        chk("pwm_u_high", 1'b1, pwm);
        tick(1);
        chk("outputs", 6'h3F, mpo);
        cmp <= 3'h6;
        tick(1);
        chk("pwm_u_low", 1'b0, pwm);
        cmp <= 3'h1;
        // Comparator off while clock and DAC enables are clear
        fault <= 1'b1;
        tick(500);
        chk("flag_comp_off", 1'b0, flag);
        chk("pwm_comp_off", 1'b1, pwm);
        $display("TB: test voltage done");
        // Limiter needs four consecutive samples
        ctrl.clock_enable <= 1'b1;
        ctrl.feedback_sample_count <= 3'h3;
        tick(100);
        chk("flag_early", 1'b0, flag);
        wait_on(1'b1, 1'b1, 300);
        chk("flag_set", 1'b1, flag);
        chk("pwm_cut", 1'b0, pwm);
        chk("master_kept", 1'b1, men);
        tick(1);
        chk("irq", 1'b1, irq);
        fault <= 1'b0;
        // Let a below-limit sample drop the limit first, as a standing set beats the clear
        tick(60);
        fl_clr <= 1'b1;
        @(posedge core_clk);
        fl_clr <= 1'b0;
        tick(3);
        chk("irq_clear", 1'b0, irq);
        chk("pwm_resume", 1'b1, pwm);
        $display("TB: test limiter done");
        // Full kill combination with a slow comparator
        ctrl.overcurrent_output_kill <= 1'b1;
        lag <= 8'h14;
        fault <= 1'b1;
        wait_on(1'b1, 1'b1, 300);
        chk("master_off", 1'b0, men);
        tick(1);
        chk("oe_kill", 6'h00, output_master_enable);
        for (int i = 0; i < 3; i++) begin
            rso <= opts[i];
            tick(3);
            chk("oe_opt", exp_oe[i], output_master_enable);
            chk("out_opt", exp_out[i], mpo);
        end
        fault <= 1'b0;
        lag <= 8'h00;
        ctrl.overcurrent_output_kill <= 1'b0;
        tick(60);
        fl_clr <= 1'b1;
        @(posedge core_clk);
        fl_clr <= 1'b0;
        tick(1);
        chk("flag_cleared", 1'b0, flag);
        $display("TB: test kill done");
        // Current mode with full blanking and single sample
        ctrl.current_mode_select <= 1'b1;
        ctrl.clock_enable <= 1'b0;
        ctrl.dac_enable <= 1'b1;
        ctrl.ref_out_enable <= 3'h7;
        ctrl.blanking_window_len <= 3'h7;
        ctrl.feedback_sample_count <= 3'h0;
        cmp <= 3'h5;
        arm();
        tick(3);
        chk("ref_out", 3'h5, {ref_w, ref_v, ref_u});
        wait_on(1'b0, 1'b0, 1200);
        wait_on(1'b0, 1'b1, 1200);
        chk("window_on", 1'b1, pwm);
        fault <= 1'b1;
        tick(170);
        chk("blanked", 1'b1, pwm);
        wait_on(1'b0, 1'b0, 120);
        chk("current_cut", 1'b0, pwm);
        chk("irq_cur_mode", 1'b0, irq);
        fault <= 1'b0;
        $display("TB: test current done");
        // Window period follows the rate select: rising edge to rising edge
        ctrl.window_rate_select <= 4'h3;
        wait_on(1'b0, 1'b0, 2500);
        wait_on(1'b0, 1'b1, 2500);
        cyc = 0;
        while (pwm === 1'b1 && cyc < 5000) begin
            tick(1);
            cyc++;
        end
        while (pwm !== 1'b1 && cyc < 5000) begin
            tick(1);
            cyc++;
        end
        chk_cnt("window_period", 24'(WIN_NS[3] / 1000 * CLK_KHZ / 1000), 24'(cyc));
        $display("TB: test window done");
        finish_test();
    end
endmodule
